// ==== design/crcb_engine.v ====
// Purpose: Byte-wide register access and CRC folding of the CRC engine.
// Assumes: Core accesses registers by page, address, write and read strobes.
// Notes:   Input bytes queue in a FIFO and fold one per clock.
// Overview of operation
// R1: Two-bit pointer selects result byte reached by next data-port access.
// R2: Pointer increments after every result data port read or write.
// R3: 32-bit mode: pointer 0..3 maps to bits 7-0,15-8,23-16,31-24.
// R4: 16-bit mode: pointer 00,10 give bits 7-0; 01,11 give 15-8.
// R5: Every input byte folds into the result with selected polynomial.
// R6: Input port is read/write, page 0xF address 0x93, resets zero.
// R7: Starting automatic CRC may corrupt the third fetched opcode byte.
// R8: Core follows start with harmless three-byte instruction.
// R9: Pointer wraps from 11 back to 00.
// R10: Select bit clear gives 32-bit poly, set gives 16-bit poly.
// R11: Writing init bit loads result with zeros or ones per value bit.
// R12: Each result data access targets byte shown by the pointer.
// R13: With auto enable set, any control write starts automatic CRC.
`timescale 1ns/1ps
`include "crcb_regs.vh"
module crcb_engine (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [3:0] sfr_page,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  output reg        input_busy,
  output reg        auto_start,
  output reg        fetch_unsafe
);
  reg  [1:0]  result_byte_pointer_q;
  reg         poly_select_q;
  reg         init_value_select_q;
  reg  [31:0] crc_q;
  reg  [7:0]  crc_byte_input_q;
  reg  [7:0]  bit_reverse_port_q;
  reg         auto_calc_enable_q;
  reg  [5:0]  start_sector_q;
  reg  [5:0]  sector_count_q;
  reg  [7:0]  rdata_d;
  wire        sel;
  wire        wr_ctrl;
  wire        wr_res;
  wire        rd_res;
  wire        wr_in;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire [31:0] crc_fold;
  wire        wr_flip;
  wire        wr_auto;
  wire        wr_cnt;
  wire [1:0]  cur_lane;

  // Folds one byte MSB first; the 16-bit mode uses the low half.
  function [31:0] fold_byte;
    input [31:0] crc;
    input [7:0]  data;
    input        mode16;
    integer      i;
    reg   [31:0] c;
    begin
      c = crc;
      for (i = 7; i >= 0; i = i - 1)
      begin
        if (mode16)
          c = {16'h0000, (c[15] ^ data[i]) ? ({c[14:0], 1'b0} ^ `CRCB_POLY16)
                                            : {c[14:0], 1'b0}};
        else
          c = (c[31] ^ data[i]) ? ({c[30:0], 1'b0} ^ `CRCB_POLY32)
                                : {c[30:0], 1'b0};
      end
      fold_byte = c;
    end
  endfunction

  // Picks the byte lane addressed by the pointer in either mode.
  function [1:0] lane;
    input [1:0] ptr;
    input       mode16;
    begin
      lane = mode16 ? {1'b0, ptr[0]} : ptr; // [R3] [R4]
    end
  endfunction

  // Page and address decode of the register strobes.
  assign sel      = (sfr_page == `CRCB_PAGE);
  assign wr_ctrl  = sel && sfr_wr && (sfr_addr == `CRCB_ADDR_CTRL);
  assign wr_res   = sel && sfr_wr && (sfr_addr == `CRCB_ADDR_RESULT);
  assign rd_res   = sel && sfr_rd && (sfr_addr == `CRCB_ADDR_RESULT);
  assign wr_in    = sel && sfr_wr && (sfr_addr == `CRCB_ADDR_INPUT); // [R6]
  assign crc_fold = fold_byte(crc_q, fifo_out_data, poly_select_q);
  assign wr_flip  = sel && sfr_wr && (sfr_addr == `CRCB_ADDR_FLIP);
  assign wr_auto  = sel && sfr_wr && (sfr_addr == `CRCB_ADDR_AUTO);
  assign wr_cnt   = sel && sfr_wr && (sfr_addr == `CRCB_ADDR_CNT);
  assign cur_lane = lane(result_byte_pointer_q, poly_select_q); // [R3] [R4]

  crcb_fifo #(
    .WIDTH (8),
    .DEPTH (`CRCB_FIFO_DEPTH),
    .AW    (`CRCB_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_in),
    .in_ready  (fifo_in_ready),
    .in_data   (sfr_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (~wr_ctrl && ~wr_res),
    .out_data  (fifo_out_data)
  );

  // Read multiplexer; unmapped addresses read zero.
  always @*
  begin
    rdata_d = `CRCB_ZERO8;
    if (sel)
    begin
      case (sfr_addr)
        `CRCB_ADDR_CTRL:
          rdata_d = {3'b000, poly_select_q, 1'b0, init_value_select_q,
                     result_byte_pointer_q};
        `CRCB_ADDR_RESULT:
          rdata_d = crc_q[`CRCB_BYTE_W*cur_lane +: `CRCB_BYTE_W]; // [R12] [R1]
        `CRCB_ADDR_INPUT:
          rdata_d = crc_byte_input_q;
        `CRCB_ADDR_FLIP:
          rdata_d = {bit_reverse_port_q[0], bit_reverse_port_q[1], bit_reverse_port_q[2],
                     bit_reverse_port_q[3], bit_reverse_port_q[4], bit_reverse_port_q[5],
                     bit_reverse_port_q[6], bit_reverse_port_q[7]};
        `CRCB_ADDR_AUTO:
          rdata_d = {auto_calc_enable_q, `CRCB_DONE_RD, start_sector_q};
        `CRCB_ADDR_CNT:
          rdata_d = {2'b00, sector_count_q};
        default:
          rdata_d = `CRCB_ZERO8;
      endcase
    end
  end

  // Result byte pointer: loaded by a control write, stepped by each result access.
  // A control write wins, so software can re-aim the pointer in the same cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
      result_byte_pointer_q <= `CRCB_PTR_RST;
    else if (wr_ctrl)
      result_byte_pointer_q <= sfr_wdata[`CRCB_PTR_MSB:`CRCB_FIELD_LSB];
    else if (wr_res || rd_res)
      result_byte_pointer_q <= result_byte_pointer_q + `CRCB_PTR_STEP; // [R2] [R9]
  end

  // Control fields: polynomial select and init value select.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      poly_select_q       <= 1'b0;
      init_value_select_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      poly_select_q       <= sfr_wdata[`CRCB_BIT_SEL]; // [R10]
      init_value_select_q <= sfr_wdata[`CRCB_BIT_VAL];
    end
  end

  // CRC result: a control write or a result byte write stalls the fold for one cycle.
  // The stalled byte stays in the FIFO output stage, so no input byte is lost.
  always @(posedge clk)
  begin
    if (!rst_n)
      crc_q <= `CRCB_ZERO32;
    else if (wr_ctrl)
    begin
      if (sfr_wdata[`CRCB_BIT_INIT])
        crc_q <= sfr_wdata[`CRCB_BIT_VAL] ? `CRCB_ONES : `CRCB_ZERO32; // [R11]
    end
    else if (wr_res)
      crc_q[`CRCB_BYTE_W*cur_lane +: `CRCB_BYTE_W] <= sfr_wdata; // [R1] [R12]
    else if (fifo_out_valid)
      crc_q <= crc_fold; // [R5] [R10]
  end

  // Data input port keeps the last written byte for readback.
  always @(posedge clk)
  begin
    if (!rst_n)
      crc_byte_input_q <= `CRCB_ZERO8; // [R6]
    else if (wr_in)
      crc_byte_input_q <= sfr_wdata; // [R6]
  end

  // Bit-reverse, automatic-run and sector count registers.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_reverse_port_q <= `CRCB_ZERO8;
      auto_calc_enable_q <= 1'b0;
      start_sector_q     <= `CRCB_SECT_RST;
      sector_count_q     <= `CRCB_SECT_RST;
    end
    else
    begin
      if (wr_flip)
        bit_reverse_port_q <= sfr_wdata;
      if (wr_auto)
      begin
        auto_calc_enable_q <= sfr_wdata[`CRCB_BIT_AUTO_CALC_ENABLE];
        start_sector_q     <= sfr_wdata[`CRCB_SECT_MSB:`CRCB_FIELD_LSB];
      end
      if (wr_cnt)
        sector_count_q <= sfr_wdata[`CRCB_SECT_MSB:`CRCB_FIELD_LSB];
    end
  end

  // Registered outputs: read data, FIFO full flag and start pulses.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sfr_rdata    <= `CRCB_ZERO8;
      input_busy   <= 1'b0;
      auto_start   <= 1'b0;
      fetch_unsafe <= 1'b0;
    end
    else
    begin
      sfr_rdata    <= rdata_d;
      input_busy   <= ~fifo_in_ready;
      auto_start   <= wr_ctrl && auto_calc_enable_q; // [R13]
      // Warns that the third opcode byte fetched next may be corrupt.
      fetch_unsafe <= wr_ctrl && auto_calc_enable_q; // [R7]
    end
  end
endmodule

// ==== design/crcb_fifo.v ====
// Purpose: Byte FIFO between the input port and the CRC fold logic.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Read data come out of a register; depth is a power of two.
`timescale 1ns/1ps
module crcb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            empty;
  wire            full;
  wire            pop;

  // Full when pointers differ only in the wrap bit.
  assign empty    = (wr_q == rd_q);
  assign full     = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = ~full;
  assign pop      = ~empty && (~out_valid || out_ready);

  // Storage write.
  always @(posedge clk)
  begin
    if (in_valid && ~full)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  // Pointers and registered output stage.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q      <= {(AW+1){1'b0}};
      rd_q      <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (in_valid && ~full)
        wr_q <= wr_q + 1'b1;
      if (pop)
      begin
        rd_q      <= rd_q + 1'b1;
        out_data  <= mem[rd_q[AW-1:0]];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

// ==== pkg/crcb_regs.vh ====
// Purpose: Register addresses, field positions and constants of the CRC byte engine.
// Assumes: Special function register page 0xF, byte-wide register bus.
// Notes:   Included by the engine design file by bare name.
`ifndef CRCB_REGS_VH
`define CRCB_REGS_VH
`define CRCB_PAGE          4'hF
`define CRCB_ADDR_CTRL     8'h92
`define CRCB_ADDR_RESULT   8'h91
`define CRCB_ADDR_INPUT    8'h93
`define CRCB_ADDR_FLIP     8'h95
`define CRCB_ADDR_AUTO     8'h96
`define CRCB_ADDR_CNT      8'h97
`define CRCB_BIT_SEL       4
`define CRCB_BIT_INIT      3
`define CRCB_BIT_VAL       2
`define CRCB_BIT_AUTO_CALC_ENABLE    7
`define CRCB_BIT_DONE      6
`define CRCB_POLY32        32'h04C11DB7
`define CRCB_POLY16        16'h1021
`define CRCB_ONES          32'hFFFFFFFF
`define CRCB_ZERO8         8'h00
`define CRCB_ZERO32        32'h00000000
`define CRCB_FIFO_DEPTH    32
`define CRCB_FIFO_AW       5
`define CRCB_BYTE_W        8
`define CRCB_PTR_MSB       1
`define CRCB_FIELD_LSB     0
`define CRCB_PTR_RST       2'h0
`define CRCB_PTR_STEP      2'h1
`define CRCB_SECT_MSB      5
`define CRCB_SECT_RST      6'h00
`define CRCB_DONE_RD       1'h1
`endif

// ==== test/crcb_checker.sv ====
// Purpose: Port assertions for the CRC byte engine.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to crcb_engine below.
`timescale 1ns/1ps
module crcb_checker (
  input wire       clk,
  input wire       rst_n,
  input wire [3:0] sfr_page,
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire       input_busy,
  input wire       auto_start,
  input wire       fetch_unsafe
);
  // Every property uses the system clock and is off during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Control writes and result port accesses on this page.
  wire ctrl_wr = sfr_wr && sfr_page == 4'hF && sfr_addr == 8'h92;
  wire dat_acc = (sfr_wr || sfr_rd) && sfr_page == 4'hF && sfr_addr == 8'h91;
  sequence s_rd(a); sfr_rd && sfr_page == 4'hF && sfr_addr == a; endsequence
  sequence s_wr(a); sfr_wr && sfr_page == 4'hF && sfr_addr == a; endsequence
  // Start pulses, register readback, pointer stepping and lane targeting.
  property p_pair; auto_start == fetch_unsafe; endproperty
  a_pair: assert property (p_pair) else $error("start pair");
  property p_cause; auto_start |-> $past(ctrl_wr); endproperty
  a_cause: assert property (p_cause) else $error("start cause");
  property p_pulse; auto_start |=> !auto_start || $past(ctrl_wr); endproperty
  a_pulse: assert property (p_pulse) else $error("start width");
  property p_inrw;
    !input_busy ##0 s_wr(8'h93) ##1 s_rd(8'h93) |=> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  a_inrw: assert property (p_inrw) else $error("input port");
  property p_init;
    s_wr(8'h92) ##0 sfr_wdata[3] ##1 s_rd(8'h91) |=> sfr_rdata == {8{$past(sfr_wdata[2], 2)}};
  endproperty
  a_init: assert property (p_init) else $error("init value");
  property p_ctrl;
    s_wr(8'h92) ##0 sfr_wdata[3] ##1 s_rd(8'h92) |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h17);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  property p_ptr;
    s_rd(8'h92) ##1 dat_acc ##1 s_rd(8'h92) |=> sfr_rdata[1:0] == $past(sfr_rdata[1:0], 2) + 2'b01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step");
  property p_lane;
    s_rd(8'h92) ##1 s_wr(8'h91) ##1 (ctrl_wr && (sfr_wdata & 8'h1B) == ($past(sfr_rdata) & 8'h13))
    ##1 s_rd(8'h91) |=> sfr_rdata == $past(sfr_wdata, 3);
  endproperty
  a_lane: assert property (p_lane) else $error("lane target");
endmodule
bind crcb_engine crcb_checker chk_u (.clk(clk), .rst_n(rst_n), .sfr_page(sfr_page),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .input_busy(input_busy), .auto_start(auto_start),
  .fetch_unsafe(fetch_unsafe));

// ==== test/crcb_core_model.sv ====
// Purpose: Core model driving the register bus.
// Assumes: Strobes change just after a rising edge.
// Notes:   Pads control writes that start an automatic run.
`timescale 1ns/1ps
module crcb_core_model (
  input  wire       clk,
  output reg  [3:0] sfr_page,
  output reg  [7:0] sfr_addr,
  output reg        sfr_wr,
  output reg        sfr_rd,
  output reg  [7:0] sfr_wdata
);
  reg auto_on = 1'b0;
  // The bus starts deselected.
  initial {sfr_page, sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = 22'h0;
  // One access, held until the next access or idle.
  task acc(input w, input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    {sfr_page, sfr_addr, sfr_wr, sfr_rd, sfr_wdata} <= {4'hF, a, w, !w, d};
    if (w && a == 8'h96) auto_on = d[7];
    if (w && a == 8'h92 && auto_on)
    begin
      @(posedge clk);
      {sfr_addr, sfr_wdata} <= {8'h95, 8'hC0}; // Harmless filler write.
    end
  end
  endtask
  // Release: deselect and invert stale address and data.
  task idle;
  begin
    @(posedge clk);
    {sfr_page, sfr_addr, sfr_wr, sfr_rd, sfr_wdata} <= {4'h0, ~sfr_addr, 2'b00, ~sfr_wdata};
  end
  endtask
endmodule

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the CRC byte engine.
// Assumes: The core model drives the register bus.
// Notes:   Reads note expectations; a watcher compares answers.
`timescale 1ns/1ps
module tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         rd_seen = 1'b0;
  wire [3:0]  sfr_page;
  wire [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  wire        sfr_wr, sfr_rd, input_busy, auto_start, fetch_unsafe;
  reg  [7:0]  exp_q[$];
  reg  [31:0] crc;
  reg  [7:0]  b;
  integer     failures = 0, n_compared = 0, cycles = 0, n_auto = 0, n_unsafe = 0, i;
  crcb_core_model core_u (.clk(clk), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
  crcb_engine dut_u (.clk(clk), .rst_n(rst_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .input_busy(input_busy), .auto_start(auto_start), .fetch_unsafe(fetch_unsafe));
  // 100 MHz clock.
  always #5 clk = ~clk;
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task end_sim;
  begin
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d); core_u.acc(1'b1, a, d); endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    exp_q.push_back(e);
    core_u.acc(1'b0, a, 8'h00);
  end
  endtask
  // Bitwise reference CRC, most significant bit first.
  function [31:0] fold(input [31:0] c, input [7:0] d, input m);
    integer j;
    begin
      for (j = 7; j >= 0; j--)
        c = (c << 1) ^ (((m ? c[15] : c[31]) ^ d[j]) ? (m ? 32'h1021 : 32'h04C11DB7) : 32'h0);
      fold = m ? {16'h0, c[15:0]} : c;
    end
  endfunction
  // Init, fold random bytes, then read five lanes from pointer 00.
  task batch(input m, input [7:0] ctl, input [31:0] c0);
  begin
    wr(8'h92, ctl);
    rd(8'h92, ctl & 8'h17);
    crc = c0;
    repeat (4)
    begin
      b = 8'($urandom);
      wr(8'h93, b);
      crc = fold(crc, b, m);
    end
    rd(8'h93, b);
    core_u.idle;
    repeat (8) @(posedge clk);
    @(negedge clk) chk(input_busy, 1'b0);
    wr(8'h92, {3'b000, m, 4'h0});
    for (i = 0; i < 5; i++) rd(8'h91, crc[8 * (m ? i % 2 : i % 4) +: 8]);
  end
  endtask
  // Watcher pops one expectation per read answer; also counts starts and cycles.
  always @(posedge clk)
  begin
    rd_seen <= sfr_rd && sfr_page == 4'hF;
    if (auto_start === 1'b1) n_auto++;
    if (fetch_unsafe === 1'b1) n_unsafe++;
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_sim;
    end
  end
  always @(negedge clk)
    if (rd_seen && exp_q.size() > 0) chk(sfr_rdata, exp_q.pop_front());
  initial
  begin
    i = $urandom(32'hCAAF);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h93, 8'h00);
    wr(8'h92, 8'h0C);
    rd(8'h91, 8'hFF);
    batch(1'b0, 8'h0C, 32'hFFFFFFFF);
    batch(1'b1, 8'h18, 32'h0);
    rd(8'h92, 8'h11);
    wr(8'h91, 8'h5A);
    wr(8'h92, 8'h11);
    rd(8'h91, 8'h5A);
    rd(8'h92, 8'h12);
    rd(8'h91, crc[7:0]);
    rd(8'h92, 8'h13);
    rd(8'h91, 8'h5A);
    rd(8'h92, 8'h10);
    wr(8'h96, 8'h80);
    rd(8'h96, 8'hC0);
    wr(8'h97, 8'h3C);
    rd(8'h97, 8'h3C);
    wr(8'h92, 8'h10);
    rd(8'h95, 8'h03);
    core_u.idle;
    repeat (3) @(posedge clk);
    chk(n_auto, 1);
    chk(n_unsafe, 1);
    end_sim;
  end
endmodule
